//--- hw/ltou_pkg.sv
package ltou_pkg;
	// Bus and block geometry
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int BOFF_W = 5;
	localparam int BLK_SH = 5;
	localparam int NBLK_DEF = 4;
	localparam int TALLY_W_DEF = 16;

	// Global register byte addresses
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_ERR = 8'h04;
	localparam logic [ADDR_W-1:0] REG_INIT = 8'h08;
	localparam logic [ADDR_W-1:0] BLK_BASE = 8'h40;

	// Per-block register offsets inside one block window
	localparam logic [BOFF_W-1:0] BOFF_CTRL = 5'h00;
	localparam logic [BOFF_W-1:0] BOFF_OFFSET = 5'h04;
	localparam logic [BOFF_W-1:0] BOFF_LOWER = 5'h08;
	localparam logic [BOFF_W-1:0] BOFF_UPPER = 5'h0c;
	localparam logic [BOFF_W-1:0] BOFF_SEL = 5'h10;
	localparam logic [BOFF_W-1:0] BOFF_TALLY = 5'h14;
	localparam logic [BOFF_W-1:0] BOFF_RESULT = 5'h18;

	// Field positions
	localparam int CTRL_FAST_BIT = 0;
	localparam int CTRL_CMDRST_BIT = 1;
	localparam int INIT_IMM_BIT = 0;
	localparam int INIT_CONT_BIT = 1;
	localparam int INIT_QUERY_BIT = 2;
	localparam int BC_OFFEN = 0;
	localparam int BC_LIMEN = 1;
	localparam int BC_REL = 2;
	localparam int BC_POL_LSB = 4;
	localparam int BC_POLQ = 6;
	localparam int BC_FAIL = 7;
	localparam int SEL_TGT_LSB = 0;
	localparam int SEL_KIND_LSB = 2;
	localparam int SEL_QONLY_BIT = 4;
	localparam logic [1:0] POL_RESERVED = 2'h3;

	// Values in thousandths of a dB (dBm for absolute units)
	localparam logic signed [DATA_W-1:0] OFF_MIN = -32'sd100000;
	localparam logic signed [DATA_W-1:0] OFF_MAX = 32'sd100000;
	localparam logic signed [DATA_W-1:0] OFF_DEF = 32'sd0;
	localparam logic signed [DATA_W-1:0] ABS_MIN = -32'sd150000;
	localparam logic signed [DATA_W-1:0] ABS_MAX = 32'sd230000;
	localparam logic signed [DATA_W-1:0] REL_MIN = -32'sd180000;
	localparam logic signed [DATA_W-1:0] REL_MAX = 32'sd200000;
	localparam logic signed [DATA_W-1:0] LOW_DEF_ABS = -32'sd90000;
	localparam logic signed [DATA_W-1:0] LOW_DEF_REL = -32'sd120000;
	localparam logic signed [DATA_W-1:0] UPP_DEF_ABS = 32'sd90000;
	localparam logic signed [DATA_W-1:0] UPP_DEF_REL = 32'sd120000;

	// Error codes
	localparam logic signed [DATA_W-1:0] ERR_NONE = 32'sd0;
	localparam logic signed [DATA_W-1:0] ERR_CONFLICT = -32'sd221;

	typedef enum logic [1:0] {POL_OFF, POL_ON, POL_ONCE} ltou_policy_type;
	typedef enum logic [1:0] {SEL_DEF, SEL_MIN, SEL_MAX} ltou_sel_type;
	typedef enum logic [1:0] {TGT_OFFSET, TGT_LOWER, TGT_UPPER} ltou_tgt_type;

	// Value named by a default/min/max selector
	function automatic logic signed [DATA_W-1:0] ltou_pick(input logic [1:0] tgt,
		input logic [1:0] kind, input logic rel);
		logic signed [DATA_W-1:0] lo;
		logic signed [DATA_W-1:0] hi;
		logic signed [DATA_W-1:0] df;
		lo = (tgt == TGT_OFFSET) ? OFF_MIN : (rel ? REL_MIN : ABS_MIN);
		hi = (tgt == TGT_OFFSET) ? OFF_MAX : (rel ? REL_MAX : ABS_MAX);
		df = (tgt == TGT_OFFSET) ? OFF_DEF : (tgt == TGT_LOWER) ?
			(rel ? LOW_DEF_REL : LOW_DEF_ABS) : (rel ? UPP_DEF_REL : UPP_DEF_ABS);
		return (kind == SEL_MIN) ? lo : (kind == SEL_MAX) ? hi : df;
	endfunction
endpackage

//--- hw/ltou_clamp.sv
`timescale 1ns/10ps
// Limits a written setting to its legal range
module ltou_clamp #(
	parameter int W = 32
) (
	// Value and range
	input wire logic signed [W-1:0] value,
	input wire logic signed [W-1:0] lo,
	input wire logic signed [W-1:0] hi,
	// Result
	output logic signed [W-1:0] clamped
);
	// Out-of-range settings land on the nearer end
	assign clamped = (value < lo) ? lo : ((value > hi) ? hi : value);
endmodule

//--- hw/ltou_tally.sv
`timescale 1ns/10ps
// Failure tally of one calculation block with its auto-clear policy
module ltou_tally import ltou_pkg::*; #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Events
	input wire logic clrNow,
	input wire logic initEvt,
	input wire logic armOnce,
	input wire logic failEvt,
	input wire ltou_policy_type policy,
	// State
	output logic [W-1:0] tally,
	output logic armed,
	output logic fail
);
	logic [W-1:0] tally_ff;
	logic armed_ff;
	logic fail_ff;
	logic [W-1:0] nxt_tally;
	wire autoClr;
	wire clr;

	// Automatic clears on initiation
	assign autoClr = initEvt & ((policy == POL_ON) | ((policy == POL_ONCE) & armed_ff));
	assign clr = clrNow | autoClr;
	// A failure in the clearing cycle survives; the count wraps past the top
	assign nxt_tally = failEvt ? (clr ? W'(1) : tally_ff + W'(1)) : (clr ? '0 : tally_ff);

	// Tally, once-arm and fail flag
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tally_ff <= '0;
			armed_ff <= 1'b1;
			fail_ff <= 1'b0;
		end else begin
			tally_ff <= nxt_tally;
			fail_ff <= (nxt_tally != '0);
			if (armOnce) begin
				armed_ff <= 1'b1;
			end else if (autoClr && policy == POL_ONCE) begin
				armed_ff <= 1'b0;
			end
		end
	end

	assign tally = tally_ff;
	assign armed = armed_ff;
	assign fail = fail_ff;
endmodule

//--- hw/ltou_unit.sv
`timescale 1ns/10ps
module ltou_unit import ltou_pkg::*; #(
	parameter int NBLK = NBLK_DEF,
	parameter int TALLY_W = TALLY_W_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Results from the math stage
	input wire logic [NBLK-1:0] measValid,
	input wire logic [NBLK*DATA_W-1:0] measValue,
	// Post-processed results
	output logic [NBLK-1:0] resValid,
	output logic [NBLK*DATA_W-1:0] resValue,
	output logic [NBLK-1:0] limitFail
);
	localparam int IDX_W = (NBLK > 1) ? $clog2(NBLK) : 1;
	localparam int BLK_SPAN = NBLK << BLK_SH;

	// Bus state
	logic pready_ff;
	logic pslverr_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic fast_ff;
	logic signed [DATA_W-1:0] errCode_ff;

	// Per-block state
	logic offEn_ff [NBLK];
	logic limEn_ff [NBLK];
	logic rel_ff [NBLK];
	ltou_policy_type policy_ff [NBLK];
	logic signed [DATA_W-1:0] offset_ff [NBLK];
	logic signed [DATA_W-1:0] lower_ff [NBLK];
	logic signed [DATA_W-1:0] upper_ff [NBLK];
	logic signed [DATA_W-1:0] extreme_ff [NBLK];
	logic signed [DATA_W-1:0] res_ff [NBLK];
	logic [NBLK-1:0] resValid_ff;
	logic [TALLY_W-1:0] tallyW [NBLK];
	logic [NBLK-1:0] armedW;
	logic [NBLK-1:0] failW;
	logic [NBLK-1:0] errPulse;

	// APB phase decode: one wait state, then the access completes
	wire accessPh = psel & penable;
	wire apbDone = accessPh & pready_ff;
	wire apbWr = apbDone & pwrite;

	// Address decode
	wire [ADDR_W-1:0] blkRel = paddr - BLK_BASE;
	wire blkHit = (paddr >= BLK_BASE) && ({1'b0, blkRel} < (ADDR_W + 1)'(BLK_SPAN));
	wire [IDX_W-1:0] blkIdx = blkRel[BLK_SH +: IDX_W];
	wire [BOFF_W-1:0] boff = paddr[BOFF_W-1:0];
	wire boffOk = (boff == BOFF_CTRL) | (boff == BOFF_OFFSET) | (boff == BOFF_LOWER) |
		(boff == BOFF_UPPER) | (boff == BOFF_SEL) | (boff == BOFF_TALLY) |
		(boff == BOFF_RESULT);
	wire glbHit = (paddr == REG_CTRL) | (paddr == REG_ERR) | (paddr == REG_INIT);
	wire mapped = glbHit | (blkHit & boffOk);

	// Device-wide command pulses
	wire cmdRst = apbWr & (paddr == REG_CTRL) & pwdata[CTRL_CMDRST_BIT];
	wire initEvt = apbWr & (paddr == REG_INIT) &
		(pwdata[INIT_IMM_BIT] | pwdata[INIT_CONT_BIT] | pwdata[INIT_QUERY_BIT]);

	// Write data fields shared by all blocks
	wire [1:0] polField = pwdata[BC_POL_LSB +: 2];
	wire [1:0] selTgt = pwdata[SEL_TGT_LSB +: 2];
	wire [1:0] selKind = pwdata[SEL_KIND_LSB +: 2];
	wire selQuery = pwdata[SEL_QONLY_BIT];
	wire relSel = rel_ff[blkIdx];
	wire signed [DATA_W-1:0] pickVal = ltou_pick(selTgt, selKind, relSel);

	// Range of the setting being written, in the addressed block's units
	wire isOffTgt = (boff == BOFF_OFFSET);
	wire signed [DATA_W-1:0] rangeLo = isOffTgt ? OFF_MIN : (relSel ? REL_MIN : ABS_MIN);
	wire signed [DATA_W-1:0] rangeHi = isOffTgt ? OFF_MAX : (relSel ? REL_MAX : ABS_MAX);
	wire signed [DATA_W-1:0] clampedWr;

	ltou_clamp #(.W(DATA_W)) u_clamp (
		.value($signed(pwdata)),
		.lo(rangeLo),
		.hi(rangeHi),
		.clamped(clampedWr)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NBLK; gi++) begin : g_blk
			// Write strobes of this block
			wire wrI = apbWr & blkHit & (blkIdx == IDX_W'(gi));
			wire wrCtrl = wrI & (boff == BOFF_CTRL);
			wire wrOff = wrI & (boff == BOFF_OFFSET);
			wire wrLow = wrI & (boff == BOFF_LOWER);
			wire wrUpp = wrI & (boff == BOFF_UPPER);
			wire wrSel = wrI & (boff == BOFF_SEL);
			wire wrTally = wrI & (boff == BOFF_TALLY);
			wire selApply = wrSel & ~selQuery;

			// Value writes, direct or by selector
			wire offValWr = wrOff | (selApply & (selTgt == TGT_OFFSET));
			wire lowValWr = wrLow | (selApply & (selTgt == TGT_LOWER));
			wire uppValWr = wrUpp | (selApply & (selTgt == TGT_UPPER));
			wire signed [DATA_W-1:0] newVal = selApply ? pickVal : clampedWr;

			// Turn-on requests refused while the rate is fast
			wire offOnReq = offValWr | (wrCtrl & pwdata[BC_OFFEN]);
			wire offReject = offOnReq & fast_ff & ~offEn_ff[gi];
			wire limReject = wrCtrl & pwdata[BC_LIMEN] & fast_ff & ~limEn_ff[gi];

			// Policy field; the spare code leaves the policy alone
			wire polWr = wrCtrl & (polField != POL_RESERVED);
			wire polOn = polWr & (polField == POL_ON);
			wire polOnce = polWr & (polField == POL_ONCE);

			// Offset after the math stage, then the limit test
			wire signed [DATA_W-1:0] meas = measValue[gi*DATA_W +: DATA_W];
			wire signed [DATA_W-1:0] adj = offEn_ff[gi] ? meas + offset_ff[gi] : meas;
			wire outside = (adj < lower_ff[gi]) | (adj > upper_ff[gi]);
			wire failEvt = measValid[gi] & limEn_ff[gi] & outside;

			assign errPulse[gi] = offReject | limReject;

			// Settings and result of this block
			always_ff @(posedge clk) begin
				if (!nrst || cmdRst) begin
					offEn_ff[gi] <= 1'b0;
					limEn_ff[gi] <= 1'b0;
					rel_ff[gi] <= 1'b0;
					policy_ff[gi] <= POL_ON;
					offset_ff[gi] <= OFF_DEF;
					lower_ff[gi] <= LOW_DEF_ABS;
					upper_ff[gi] <= UPP_DEF_ABS;
					extreme_ff[gi] <= '0;
					res_ff[gi] <= '0;
					resValid_ff[gi] <= 1'b0;
				end else begin
					if (wrCtrl) begin
						offEn_ff[gi] <= pwdata[BC_OFFEN] & ~offReject;
						limEn_ff[gi] <= pwdata[BC_LIMEN] & ~limReject;
						rel_ff[gi] <= pwdata[BC_REL];
					end
					if (polWr) begin
						policy_ff[gi] <= ltou_policy_type'(polField);
					end
					if (offValWr) begin
						offset_ff[gi] <= newVal;
						if (!offReject) begin
							offEn_ff[gi] <= 1'b1;
						end
					end
					if (lowValWr) begin
						lower_ff[gi] <= newVal;
					end
					if (uppValWr) begin
						upper_ff[gi] <= newVal;
					end
					if (wrSel) begin
						extreme_ff[gi] <= pickVal;
					end
					resValid_ff[gi] <= measValid[gi];
					if (measValid[gi]) begin
						res_ff[gi] <= adj;
					end
				end
			end

			ltou_tally #(.W(TALLY_W)) u_tally (
				.clk(clk),
				.nrst(nrst),
				.clrNow(cmdRst | wrTally | polOn),
				.initEvt(initEvt),
				.armOnce(polOnce | cmdRst),
				.failEvt(failEvt),
				.policy(policy_ff[gi]),
				.tally(tallyW[gi]),
				.armed(armedW[gi]),
				.fail(failW[gi])
			);

			assign resValue[gi*DATA_W +: DATA_W] = res_ff[gi];
		end
	endgenerate

	// Block control read-back
	wire polQ = (policy_ff[blkIdx] == POL_ON) |
		((policy_ff[blkIdx] == POL_ONCE) & armedW[blkIdx]);
	wire [DATA_W-1:0] ctrlRd = (DATA_W'(offEn_ff[blkIdx]) << BC_OFFEN) |
		(DATA_W'(limEn_ff[blkIdx]) << BC_LIMEN) |
		(DATA_W'(rel_ff[blkIdx]) << BC_REL) |
		(DATA_W'(policy_ff[blkIdx]) << BC_POL_LSB) |
		(DATA_W'(polQ) << BC_POLQ) |
		(DATA_W'(failW[blkIdx]) << BC_FAIL);

	// Block read mux
	wire [DATA_W-1:0] blkRd =
		(boff == BOFF_CTRL) ? ctrlRd :
		(boff == BOFF_OFFSET) ? offset_ff[blkIdx] :
		(boff == BOFF_LOWER) ? lower_ff[blkIdx] :
		(boff == BOFF_UPPER) ? upper_ff[blkIdx] :
		(boff == BOFF_SEL) ? extreme_ff[blkIdx] :
		(boff == BOFF_TALLY) ? DATA_W'(tallyW[blkIdx]) :
		(boff == BOFF_RESULT) ? res_ff[blkIdx] : '0;

	// Global read mux
	wire [DATA_W-1:0] rdData =
		(paddr == REG_CTRL) ? (DATA_W'(fast_ff) << CTRL_FAST_BIT) :
		(paddr == REG_ERR) ? errCode_ff :
		(paddr == REG_INIT) ? '0 :
		blkHit ? blkRd : '0;

	// APB handshake: pready rises in the second access cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			pready_ff <= accessPh & ~pready_ff;
			if (accessPh && !pready_ff) begin
				pslverr_ff <= ~mapped;
				prdata_ff <= (mapped && !pwrite) ? rdData : '0;
			end else begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	// Rate mode and last error; a new error beats a clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fast_ff <= 1'b0;
			errCode_ff <= ERR_NONE;
		end else begin
			if (apbWr && paddr == REG_CTRL) begin
				fast_ff <= pwdata[CTRL_FAST_BIT];
			end
			if (|errPulse) begin
				errCode_ff <= ERR_CONFLICT;
			end else if (apbWr && paddr == REG_ERR) begin
				errCode_ff <= ERR_NONE;
			end
		end
	end

	// Outputs
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign resValid = resValid_ff;
	assign limitFail = failW;
endmodule

//--- test/ltou_host.sv
`timescale 1ns/10ps
// APB master standing in for the host controller
module ltou_host import ltou_pkg::*; (
	// Clock
	input wire logic clk,
	// APB master side
	output logic [ADDR_W-1:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus at time zero
	initial begin
		paddr = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = '0;
	end
	// Setup, access held until pready, then release and one idle edge
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines carry the inverse, not the old value
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge clk);
	endtask
endmodule

//--- test/ltou_unit_assertions.sv
`timescale 1ns/10ps
// Watches bus and result timing at the unit's ports
module ltou_unit_checker import ltou_pkg::*; #(
	parameter int NBLK = NBLK_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Results
	input wire logic [NBLK-1:0] measValid,
	input wire logic [NBLK-1:0] resValid,
	input wire logic [NBLK*DATA_W-1:0] resValue,
	input wire logic [NBLK-1:0] limitFail
);
	// One clock domain
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Bus handshake
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_setup_walk: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("access phase not two cycles");
	a_idle_ready: assert property (!(psel && penable) |=> !pready)
		else $error("pready without access");
	a_err_ready: assert property (pslverr |-> pready && prdata == '0)
		else $error("pslverr alone or with data");
	// Result path and fail flag
	a_res_valid: assert property (resValid == $past(measValid))
		else $error("result strobe latency");
	a_res_hold: assert property (!(|measValid) &&
		!(pready && pwrite && paddr == REG_CTRL) |=> $stable(resValue))
		else $error("result changed without input");
	a_fail_cause: assert property ($changed(limitFail) |->
		resValid != '0 || ($past(pready) && $past(pwrite)))
		else $error("fail flag moved without cause");
	a_fail_rise: assert property ((limitFail & ~$past(limitFail) & ~resValid) == '0)
		else $error("fail flag rose without result");
endmodule
bind ltou_unit ltou_unit_checker #(.NBLK(NBLK)) i_ltou_unit_checker (
	.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.measValid(measValid), .resValid(resValid), .resValue(resValue),
	.limitFail(limitFail)
);

//--- test/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module testbench import ltou_pkg::*; ;
	logic clk;
	logic nrst;
	logic [ADDR_W-1:0] paddr;
	logic psel, penable, pwrite, pready, pslverr, err;
	logic [DATA_W-1:0] pwdata, prdata, rdat, off, v;
	logic [3:0] measValid, resValid, limitFail;
	logic [4*DATA_W-1:0] measValue, resValue;
	logic [DATA_W-1:0] tv [5] = '{32'hfffffc17, 32'hfffffc18, 32'h3e8, 32'h3e9, 32'h0};
	int failures, totalChecks, cycles;
	// Device and host
	ltou_unit i_ltou_unit (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .measValid(measValid), .measValue(measValue),
		.resValid(resValid), .resValue(resValue), .limitFail(limitFail));
	ltou_host i_ltou_host (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			endSim();
		end
	end
	function automatic logic [ADDR_W-1:0] ba(input int b, input logic [BOFF_W-1:0] o);
		return BLK_BASE + ADDR_W'(b * 32) + ADDR_W'(o);
	endfunction
	// Lower limit named by a selector kind
	function automatic logic [DATA_W-1:0] lowPick(input int k, input logic rel);
		if (k == 1) return rel ? REL_MIN : ABS_MIN;
		if (k == 2) return rel ? REL_MAX : ABS_MAX;
		return rel ? LOW_DEF_REL : LOW_DEF_ABS;
	endfunction
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		i_ltou_host.xfer(1'b1, a, d, rdat, err);
	endtask
	task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string n);
		i_ltou_host.xfer(1'b0, a, '0, rdat, err);
		`CHK(n, e, rdat)
	endtask
	// One result from the math stage, checked a cycle later
	task automatic meas(input int b, input logic [DATA_W-1:0] x, input logic [DATA_W-1:0] e);
		measValid[b] <= 1'b1;
		measValue[b*DATA_W+:DATA_W] <= x;
		@(posedge clk);
		measValid[b] <= 1'b0;
		@(posedge clk);
		`CHK("res valid", 1'b1, resValid[b])
		`CHK("result", e, resValue[b*DATA_W+:DATA_W])
	endtask
	task automatic chkDefaults();
		for (int b = 0; b < 4; b++) begin
			rc(ba(b, BOFF_CTRL), 32'h50, "block ctrl");
			rc(ba(b, BOFF_OFFSET), OFF_DEF, "offset");
			rc(ba(b, BOFF_LOWER), LOW_DEF_ABS, "lower");
			rc(ba(b, BOFF_TALLY), 32'h0, "tally");
		end
		`CHK("fail flags", 4'h0, limitFail)
	endtask
	task automatic endSim();
		$display("checks %0d failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		nrst = 1'b0;
		measValid = '0;
		measValue = '0;
		void'($urandom(32'h5261));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chkDefaults();
		$display("test defaults done");
		off = DATA_W'($urandom_range(200000)) - 32'd100000;
		v = DATA_W'($urandom_range(100000));
		wr(ba(1, BOFF_OFFSET), off);
		rc(ba(1, BOFF_CTRL), 32'h51, "offset on");
		rc(ba(1, BOFF_OFFSET), off, "offset");
		meas(1, v, v + off);
		wr(ba(1, BOFF_CTRL), 32'h10);
		rc(ba(1, BOFF_CTRL), 32'h50, "offset off");
		meas(1, v, v);
		wr(ba(1, BOFF_OFFSET), 32'd200000);
		rc(ba(1, BOFF_OFFSET), OFF_MAX, "offset clamp");
		wr(ba(1, BOFF_SEL), 32'h18);
		rc(ba(1, BOFF_SEL), OFF_MAX, "max query");
		wr(ba(1, BOFF_SEL), 32'h14);
		rc(ba(1, BOFF_SEL), OFF_MIN, "min query");
		rc(ba(1, BOFF_OFFSET), OFF_MAX, "query only");
		wr(ba(1, BOFF_SEL), 32'h04);
		rc(ba(1, BOFF_OFFSET), OFF_MIN, "min select");
		wr(ba(1, BOFF_SEL), 32'h08);
		rc(ba(1, BOFF_OFFSET), OFF_MAX, "max select");
		wr(ba(1, BOFF_SEL), 32'h00);
		rc(ba(1, BOFF_OFFSET), OFF_DEF, "def select");
		for (int r = 0; r < 2; r++) begin
			for (int k = 0; k < 3; k++) begin
				wr(ba(2, BOFF_CTRL), r ? 32'h14 : 32'h10);
				wr(ba(2, BOFF_SEL), DATA_W'(k * 4 + 1));
				rc(ba(2, BOFF_LOWER), lowPick(k, r[0]), "lower pick");
			end
		end
		// Block 2 is in relative units here; pick the upper limit's minimum
		wr(ba(2, BOFF_SEL), 32'h06);
		rc(ba(2, BOFF_UPPER), REL_MIN, "upper pick");
		wr(REG_CTRL, 32'h1);
		wr(ba(2, BOFF_CTRL), 32'h11);
		rc(REG_ERR, ERR_CONFLICT, "conflict");
		rc(ba(2, BOFF_CTRL), 32'h50, "refused on");
		wr(REG_CTRL, 32'h0);
		wr(REG_ERR, 32'h0);
		$display("test offset done");
		wr(ba(2, BOFF_CTRL), 32'h02);
		wr(ba(2, BOFF_LOWER), 32'hfffffc18);
		wr(ba(2, BOFF_UPPER), 32'h3e8);
		for (int i = 0; i < 5; i++) meas(2, tv[i], tv[i]);
		rc(ba(2, BOFF_TALLY), 32'h2, "edge tally");
		rc(ba(2, BOFF_CTRL), 32'h82, "fail bit");
		`CHK("fail flag", 1'b1, limitFail[2])
		for (int i = 0; i < 3; i++) wr(REG_INIT, DATA_W'(1 << i));
		rc(ba(2, BOFF_TALLY), 32'h2, "policy off");
		wr(ba(2, BOFF_CTRL), 32'h22);
		rc(ba(2, BOFF_CTRL), 32'he2, "once armed");
		wr(REG_INIT, 32'h1);
		rc(ba(2, BOFF_CTRL), 32'h22, "once used");
		meas(2, 32'hfffff830, 32'hfffff830);
		wr(REG_INIT, 32'h4);
		rc(ba(2, BOFF_TALLY), 32'h1, "once keeps");
		wr(ba(2, BOFF_TALLY), 32'h0);
		rc(ba(2, BOFF_TALLY), 32'h0, "clear now");
		meas(2, 32'h7d0, 32'h7d0);
		wr(ba(2, BOFF_CTRL), 32'h12);
		rc(ba(2, BOFF_TALLY), 32'h0, "policy on");
		for (int i = 0; i < 3; i++) begin
			meas(2, 32'h7d0, 32'h7d0);
			wr(REG_INIT, DATA_W'(1 << i));
			rc(ba(2, BOFF_TALLY), 32'h0, "auto clear");
		end
		$display("test limits done");
		wr(ba(3, BOFF_CTRL), 32'h02);
		measValue[3*DATA_W+:DATA_W] <= 32'hfffe7960;
		measValid[3] <= 1'b1;
		repeat (65535) @(posedge clk);
		measValid[3] <= 1'b0;
		@(posedge clk);
		rc(ba(3, BOFF_TALLY), 32'hffff, "tally max");
		meas(3, 32'hfffe7960, 32'hfffe7960);
		rc(ba(3, BOFF_TALLY), 32'h0, "tally wrap");
		rc(ba(0, BOFF_TALLY), 32'h0, "other block");
		rc(ba(0, 5'h1c), 32'h0, "unmapped");
		`CHK("slave error", 1'b1, err)
		$display("test wrap done");
		wr(ba(0, BOFF_OFFSET), off);
		wr(REG_CTRL, 32'h2);
		chkDefaults();
		$display("test command reset done");
		endSim();
	end
endmodule
